// *** logic/program_space_data_window.sv ***
// Top of the program-space data window bridge
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Upper data half maps to selectable page
// - Redirect only when msb and enable set
// - Window addresses always belong to X space
// - Each address from 0x8000 up maps one word
// - Return only low 16 program bits
// - Low 15 address bits pass unchanged
// - Page register supplies upper address bits
// - Program address steps by two per word
// - Table instructions suspend window translation
// - Prefetch MAC and moves add one cycle
// - Other instructions add two cycles
// - Repeat edges and interrupts add two cycles
// - Middle repeat iterations add no cycle
module program_space_data_window (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_ctrl_wr,
  input wire logic [15:0] i_ctrl_wdata,
  input wire logic i_page_wr,
  input wire logic [7:0] i_page_wdata,
  input wire logic i_req,
  input wire logic [15:0] i_addr,
  input wire logic i_y_space,
  input wire logic i_table_op,
  input wire pwin_pkg::instr_class_t i_cls,
  input wire pwin_pkg::rep_pos_t i_rep,
  input wire logic [23:0] i_prog_rdata,
  input wire logic [15:0] i_data_rdata,
  output logic [15:0] o_core_control_reg,
  output logic [7:0] o_window_page_reg,
  output logic o_prog_req,
  output logic [23:0] o_prog_addr,
  output logic o_data_req,
  output logic o_x_space,
  output logic [15:0] o_data_addr,
  output logic [1:0] o_extra_cycles,
  output logic o_rvalid,
  output logic [15:0] o_rdata
);
  // Control registers and the decoded window enable
  logic [15:0] core_control_reg;
  logic [15:0] next_core_control_reg;
  logic [7:0] window_page_reg;
  logic [7:0] next_window_page_reg;
  logic program_window_enable;

  // Translator results
  logic hit;
  logic [23:0] paddr;

  // Access pipeline: taken request, then a one-cycle answer pulse
  logic pend;
  logic next_pend;
  logic pend_prog;
  logic next_pend_prog;
  logic rvalid;
  logic next_rvalid;

  // Returned word and its holding register
  wire logic [15:0] answer_word;
  logic [15:0] rdata;
  logic [15:0] next_rdata;

  pwin_if pbus();

  always_comb begin
    if (i_ctrl_wr) begin
      next_core_control_reg = i_ctrl_wdata;
    end else begin
      next_core_control_reg = core_control_reg;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      core_control_reg <= pwin_pkg::CORE_CTRL_RESET;
    end else if (i_ce) begin
      core_control_reg <= next_core_control_reg;
    end
  end

  // A page write lands at the edge that takes an access on the old page
  always_comb begin
    if (i_page_wr) begin
      next_window_page_reg = i_page_wdata;
    end else begin
      next_window_page_reg = window_page_reg;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      window_page_reg <= pwin_pkg::PAGE_RESET;
    end else if (i_ce) begin
      window_page_reg <= next_window_page_reg;
    end
  end

  assign program_window_enable = core_control_reg[pwin_pkg::ENABLE_BIT];

  pwin_xlate u_xlate (
    .i_addr(i_addr),
    .i_enable(program_window_enable),
    .i_table_op(i_table_op),
    .i_page(window_page_reg),
    .o_hit(hit),
    .o_paddr(paddr)
  );

  // Penalty logic only sees accesses that are really taken
  assign pbus.hit = hit & i_req;
  assign pbus.cls = i_cls;
  assign pbus.rep = i_rep;

  pwin_penalty u_penalty (
    .bus(pbus)
  );

  // Routing is combinational so the core sees it in the same cycle
  always_comb begin
    if (i_req && hit) begin
      o_prog_req = 1'h1;
    end else begin
      o_prog_req = 1'h0;
    end
  end

  always_comb begin
    o_prog_addr = paddr;
  end

  always_comb begin
    if (i_req && !hit) begin
      o_data_req = 1'h1;
    end else begin
      o_data_req = 1'h0;
    end
  end

  always_comb begin
    o_data_addr = i_addr;
  end

  // Window region is X space even for dual-operand fetches
  always_comb begin
    if (i_addr[15]) begin
      o_x_space = 1'h1;
    end else begin
      o_x_space = ~i_y_space;
    end
  end

  always_comb begin
    o_extra_cycles = pbus.extra;
  end

  // No queue: a taken access is answered exactly two cycles later
  always_comb begin
    next_rvalid = pend;
    if (i_req) begin
      next_pend = 1'h1;
      next_pend_prog = hit;
    end else begin
      next_pend = 1'h0;
      next_pend_prog = 1'h0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pend <= 1'h0;
      pend_prog <= 1'h0;
      rvalid <= 1'h0;
    end else if (i_ce) begin
      pend <= next_pend;
      pend_prog <= next_pend_prog;
      rvalid <= next_rvalid;
    end
  end

  // Only the low 16 bits of a program word are selectable; its upper byte
  // never reaches the core
  for (genvar b = 0; b < 16; b++) begin : g_answer_bit
    assign answer_word[b] = pend_prog ? i_prog_rdata[b]
      : i_data_rdata[b];
  end

  // Read data holds until the next answer replaces it
  always_comb begin
    if (pend) begin
      next_rdata = answer_word;
    end else begin
      next_rdata = rdata;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata <= 16'h0000;
    end else if (i_ce) begin
      rdata <= next_rdata;
    end
  end

  assign o_core_control_reg = core_control_reg;
  assign o_window_page_reg = window_page_reg;
  assign o_rvalid = rvalid;
  assign o_rdata = rdata;
endmodule
`default_nettype wire

// *** logic/pwin_pkg.sv ***
// Constants and types shared by the program-space data window
`default_nettype none
package pwin_pkg;
  localparam int DATA_AW = 16;
  localparam int PROG_AW = 24;
  localparam int PROG_DW = 24;
  localparam int DATA_DW = 16;
  localparam int LOW_BITS = 15;
  localparam int PAGE_W = 8;
  localparam int ENABLE_BIT = 2;
  localparam logic [15:0] CORE_CTRL_RESET = 16'h0020;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [15:0] WINDOW_BASE = 16'h8000;
  localparam logic [1:0] PEN_NONE = 2'h0;
  localparam logic [1:0] PEN_ONE = 2'h1;
  localparam logic [1:0] PEN_TWO = 2'h2;
  typedef enum logic [1:0] {
    CLS_MAC_PREFETCH = 2'b00,
    CLS_MOVE = 2'b01,
    CLS_DOUBLE_MOVE = 2'b10,
    CLS_OTHER = 2'b11
  } instr_class_t;
  typedef enum logic [2:0] {
    REP_NONE = 3'b000,
    REP_FIRST = 3'b001,
    REP_MIDDLE = 3'b010,
    REP_LAST = 3'b011,
    REP_INT_EXIT = 3'b100,
    REP_INT_REENTER = 3'b101
  } rep_pos_t;
endpackage
`default_nettype wire

// *** logic/pwin_if.sv ***
// Bundle between translator and penalty logic
`timescale 1ns/10ps
`default_nettype none
interface pwin_if;
  logic hit;
  pwin_pkg::instr_class_t cls;
  pwin_pkg::rep_pos_t rep;
  logic [1:0] extra;
  modport xlate(output hit, output cls, output rep, input extra);
  modport pen(input hit, input cls, input rep, output extra);
endinterface
`default_nettype wire

// *** logic/pwin_xlate.sv ***
// Address translation from data window to program space
`timescale 1ns/10ps
`default_nettype none
module pwin_xlate (
  input wire logic [15:0] i_addr,
  input wire logic i_enable,
  input wire logic i_table_op,
  input wire logic [7:0] i_page,
  output logic o_hit,
  output logic [23:0] o_paddr
);
  always_comb begin
    // Msb set and enabled; table ops suspend the window
    o_hit = i_addr[15] & i_enable & ~i_table_op;
    // Page supplies upper bits, low 15 pass; byte address steps by 2
    o_paddr = {i_page, i_addr[14:0], 1'h0};
  end
endmodule
`default_nettype wire

// *** logic/pwin_penalty.sv ***
// Extra-cycle penalty for window accesses
`timescale 1ns/10ps
`default_nettype none
module pwin_penalty (
  pwin_if.pen bus
);
  always_comb begin
    bus.extra = pwin_pkg::PEN_NONE;
    if (bus.hit) begin
      unique case (bus.rep)
        pwin_pkg::REP_NONE: begin
          if (bus.cls == pwin_pkg::CLS_OTHER) begin
            bus.extra = pwin_pkg::PEN_TWO;
          end else begin
            bus.extra = pwin_pkg::PEN_ONE;
          end
        end
        pwin_pkg::REP_MIDDLE: begin
          bus.extra = pwin_pkg::PEN_NONE;
        end
        pwin_pkg::REP_FIRST, pwin_pkg::REP_LAST,
        pwin_pkg::REP_INT_EXIT, pwin_pkg::REP_INT_REENTER: begin
          bus.extra = pwin_pkg::PEN_TWO;
        end
        default: begin
          bus.extra = pwin_pkg::PEN_TWO;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** tb/pwin_mem_model.sv ***
// Behavioural program and data memories behind the window
`timescale 1ns/10ps
`default_nettype none
module pwin_mem_model (
  input wire logic i_mclk,
  input wire logic i_prog_req,
  input wire logic [23:0] i_prog_addr,
  input wire logic i_data_req,
  input wire logic [15:0] i_data_addr,
  output logic [23:0] o_prog_rdata,
  output logic [15:0] o_data_rdata
);
  initial o_prog_rdata = 24'h000000;
  initial o_data_rdata = 16'h0000;
  // Idle cycles flip the bus, so a stale word never passes for an answer
  always @(posedge i_mclk) begin
    o_prog_rdata <= i_prog_req ? {i_prog_addr[23:16] ^ 8'h3c,
      i_prog_addr[16:1] ^ 16'ha5c3} : ~o_prog_rdata;
    o_data_rdata <= i_data_req ? i_data_addr ^ 16'h1234 : ~o_data_rdata;
  end
endmodule
`default_nettype wire

// *** tb/program_space_data_window_assertions.sv ***
// Port-level checks on the program-space data window
`timescale 1ns/10ps
`default_nettype none
module pwin_chk (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_req,
  input wire logic i_table_op,
  input wire logic [15:0] i_addr,
  input wire pwin_pkg::instr_class_t i_cls,
  input wire pwin_pkg::rep_pos_t i_rep,
  input wire logic [23:0] i_prog_rdata,
  input wire logic [23:0] o_prog_addr,
  input wire logic [15:0] o_core_control_reg,
  input wire logic [15:0] o_rdata,
  input wire logic [7:0] o_window_page_reg,
  input wire logic o_prog_req,
  input wire logic o_data_req,
  input wire logic o_x_space,
  input wire logic o_rvalid,
  input wire logic [1:0] o_extra_cycles
);
  wire logic hit;
  assign hit = i_addr[15] & ~i_table_op &
    o_core_control_reg[pwin_pkg::ENABLE_BIT];
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  sequence win_rd;
    i_ce && i_req && hit ##1 i_ce;
  endsequence
  prog_route_a: assert property (
    i_req && hit |-> o_prog_req && !o_data_req) else $error("no redirect");
  data_route_a: assert property (
    i_req && !hit |-> o_data_req && !o_prog_req && o_extra_cycles == 2'h0)
    else $error("plain access disturbed");
  prog_addr_a: assert property (
    hit |-> o_prog_addr == {o_window_page_reg, i_addr[14:0], 1'b0})
    else $error("bad program address");
  x_space_a: assert property (
    i_addr[15] |-> o_x_space) else $error("window not in X space");
  one_extra_a: assert property (
    i_req && hit && i_rep == pwin_pkg::REP_NONE &&
    i_cls != pwin_pkg::CLS_OTHER |-> o_extra_cycles == 2'h1)
    else $error("penalty not one");
  two_extra_a: assert property (
    i_req && hit && (i_rep == pwin_pkg::REP_NONE ?
    i_cls == pwin_pkg::CLS_OTHER : i_rep != pwin_pkg::REP_MIDDLE)
    |-> o_extra_cycles == 2'h2)
    else $error("penalty not two");
  mid_rep_a: assert property (
    i_req && hit && i_rep == pwin_pkg::REP_MIDDLE
    |-> o_extra_cycles == 2'h0)
    else $error("middle iteration penalised");
  read_data_a: assert property (
    win_rd |=> o_rvalid && o_rdata == $past(i_prog_rdata[15:0]))
    else $error("window read data wrong");
  ce_freeze_a: assert property (
    !i_ce |=> $stable(o_window_page_reg) && $stable(o_core_control_reg))
    else $error("registers moved while clock enable low");
endmodule
bind program_space_data_window pwin_chk pwin_chk_inst (
  .i_mclk(i_mclk),
  .i_sys_rst(i_sys_rst),
  .i_ce(i_ce),
  .i_req(i_req),
  .i_table_op(i_table_op),
  .i_addr(i_addr),
  .i_cls(i_cls),
  .i_rep(i_rep),
  .i_prog_rdata(i_prog_rdata),
  .o_prog_addr(o_prog_addr),
  .o_core_control_reg(o_core_control_reg),
  .o_rdata(o_rdata),
  .o_window_page_reg(o_window_page_reg),
  .o_prog_req(o_prog_req),
  .o_data_req(o_data_req),
  .o_x_space(o_x_space),
  .o_rvalid(o_rvalid),
  .o_extra_cycles(o_extra_cycles)
);
`default_nettype wire

// *** tb/program_space_data_window_tb.sv ***
// Self-checking bench for the program-space data window
`timescale 1ns/10ps
`default_nettype none
module program_space_data_window_tb;
  `define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin \
    mismatches++; $display("MISMATCH %0t got %h", $time, a); end end
  logic i_mclk = 0, i_sys_rst = 1, i_ce = 1, i_ctrl_wr = 0, i_page_wr = 0;
  logic i_req = 0, i_y_space = 0, i_table_op = 0, en, hit;
  logic [15:0] i_ctrl_wdata = 16'h0000, i_addr = 16'h0000, r = 16'h0001;
  logic [7:0] i_page_wdata = 8'h00, pg = pwin_pkg::PAGE_RESET;
  pwin_pkg::instr_class_t i_cls = pwin_pkg::CLS_MOVE;
  pwin_pkg::rep_pos_t i_rep = pwin_pkg::REP_NONE;
  logic [23:0] i_prog_rdata, o_prog_addr;
  logic [15:0] i_data_rdata, o_core_control_reg, o_data_addr, o_rdata;
  logic [7:0] o_window_page_reg;
  logic o_prog_req, o_data_req, o_x_space, o_rvalid;
  logic [1:0] o_extra_cycles;
  logic [15:0] q[$];
  int mismatches = 0, cmp_count = 0;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  always #5 i_mclk = ~i_mclk;
  program_space_data_window program_space_data_window_inst (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
    .i_ctrl_wr(i_ctrl_wr), .i_ctrl_wdata(i_ctrl_wdata),
    .i_page_wr(i_page_wr), .i_page_wdata(i_page_wdata),
    .i_req(i_req), .i_addr(i_addr), .i_y_space(i_y_space),
    .i_table_op(i_table_op), .i_cls(i_cls), .i_rep(i_rep),
    .i_prog_rdata(i_prog_rdata), .i_data_rdata(i_data_rdata),
    .o_core_control_reg(o_core_control_reg),
    .o_window_page_reg(o_window_page_reg), .o_prog_req(o_prog_req),
    .o_prog_addr(o_prog_addr), .o_data_req(o_data_req),
    .o_x_space(o_x_space), .o_data_addr(o_data_addr),
    .o_extra_cycles(o_extra_cycles), .o_rvalid(o_rvalid),
    .o_rdata(o_rdata));
  pwin_mem_model pwin_mem_model_inst (.i_mclk(i_mclk),
    .i_prog_req(o_prog_req), .i_prog_addr(o_prog_addr),
    .i_data_req(o_data_req), .i_data_addr(o_data_addr),
    .o_prog_rdata(i_prog_rdata), .o_data_rdata(i_data_rdata));
  task close_out;
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // An answer with no note queued compares against unknown and fails
  always @(negedge i_mclk) if (o_rvalid === 1'b1)
    `CHK(o_rdata, q.size() ? q.pop_front() : 16'hxxxx)
  initial begin
    repeat (10) @(negedge i_mclk);
    i_sys_rst = 0;
    `CHK(o_core_control_reg, pwin_pkg::CORE_CTRL_RESET)
    `CHK(o_window_page_reg, pwin_pkg::PAGE_RESET)
    i_ce = 0;
    i_page_wr = 1;
    i_page_wdata = 8'h77;
    @(negedge i_mclk);
    `CHK(o_window_page_reg, pwin_pkg::PAGE_RESET)
    i_ce = 1;
    for (int k = 0; k < 400; k++) begin
      if (k % 200 == 0) begin
        en = (k == 0);
        i_req = 0;
        i_page_wr = 0;
        i_ctrl_wr = 1;
        i_ctrl_wdata = {13'h0004, en, 2'h0};
        @(negedge i_mclk);
        i_ctrl_wr = 0;
        `CHK(o_core_control_reg[pwin_pkg::ENABLE_BIT], en)
      end
      r = lfsr(r);
      i_addr = r;
      i_table_op = r[3] & r[6];
      i_y_space = r[4];
      i_cls = pwin_pkg::instr_class_t'(r[9:8]);
      i_rep = pwin_pkg::rep_pos_t'(r[12:10] % 3'h6);
      i_page_wr = r[0];
      i_page_wdata = r[15:8];
      i_req = 1;
      hit = en & r[15] & ~i_table_op;
      q.push_back(hit ? {pg[0], r[14:0]} ^ 16'ha5c3 : r ^ 16'h1234);
      if (r[0]) pg = r[15:8];
      @(negedge i_mclk);
    end
    i_req = 0;
    i_page_wr = 0;
    for (int w = 0; w < 8 && q.size() != 0; w++) @(negedge i_mclk);
    if (q.size() != 0) begin
      mismatches++;
      $display("MISMATCH %0t answers missing", $time);
    end
    close_out();
  end
endmodule
`default_nettype wire
